/* File: verilog/sacl_defines.svh */
// Register map, field positions and timing in ns of the attenuator controller
`ifndef SACL_DEFINES_SVH
`define SACL_DEFINES_SVH
`define SACL_ADDR_CTRL 12'h000
`define SACL_ADDR_SET 12'h004
`define SACL_ADDR_STAT 12'h008
`define SACL_CTRL_DIRECT 0
`define SACL_CTRL_GO 1
`define SACL_SET_W 4
`define SACL_STEP_MAX 4'hb
`define SACL_STEP_8DB 4'h4
`define SACL_STEP_16DB 4'h8
`define SACL_CODE_MAX 4'hf
`define SACL_SETUP_NS 20
`define SACL_PULSE_NS 20
`define SACL_HOLD_NS 20
`define SACL_CLK_NS 8
`endif

/* File: verilog/sacl_pkg.sv */
// Types shared by the attenuator controller files
package sacl_pkg;
  typedef enum logic [4:0] {
    SACL_IDLE = 5'b00001,
    SACL_SETUP = 5'b00010,
    SACL_PULSE = 5'b00100,
    SACL_HOLD = 5'b01000,
    SACL_DIR = 5'b10000
  } sacl_state_type;
endpackage

/* File: verilog/sacl_tick.sv */
// Cycle counter giving a one-cycle done pulse after a loaded count
`timescale 1ns/1ns
module sacl_tick #(
  parameter int W = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic [W-1:0] count,
  output logic done
);
  logic [W-1:0] cnt_ff;
  logic run_ff;
  wire last = run_ff && (cnt_ff == '0);
  assign done = last;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_ff <= '0;
      run_ff <= 1'b0;
    end
    else if (start)
    begin
      cnt_ff <= count;
      run_ff <= 1'b1;
    end
    else if (last)
      run_ff <= 1'b0;
    else if (run_ff)
      cnt_ff <= cnt_ff - 1'b1;
  end
endmodule

/* File: verilog/sacl_ctrl.sv */
// APB controller driving the parallel attenuator control and latch pins
`timescale 1ns/1ns
`include "sacl_defines.svh"
module sacl_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic weight_2db_ctl,
  output logic weight_4db_ctl,
  output logic weight_8db_ctl_a,
  output logic weight_8db_ctl_b,
  output logic latch_load_enable
);
  // ------------------------------------------------------------------
  // Timing counts
  // ------------------------------------------------------------------
  localparam int SETUP_CYC =
    (`SACL_SETUP_NS + `SACL_CLK_NS - 1) / `SACL_CLK_NS;
  localparam int PULSE_CYC =
    (`SACL_PULSE_NS + `SACL_CLK_NS - 1) / `SACL_CLK_NS;
  localparam int HOLD_CYC =
    (`SACL_HOLD_NS + `SACL_CLK_NS - 1) / `SACL_CLK_NS;

  // Step count (0..11) to pin code, 8 dB input a first
  function automatic logic [3:0] step_to_code(input logic [3:0] step);
    logic [3:0] s;
    logic [3:0] c;
    s = (step > `SACL_STEP_MAX) ? `SACL_STEP_MAX : step;
    c = {2'b00, s[1:0]};
    if (s >= `SACL_STEP_16DB)
      c[3:2] = 2'b11;
    else if (s >= `SACL_STEP_8DB)
      c[2] = 1'b1;
    return c;
  endfunction

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  logic direct_ff;
  logic [3:0] step_ff;
  logic [3:0] code_ff;
  logic load_en_ff;
  logic [3:0] applied_ff;
  logic [31:0] prdata_ff;
  sacl_pkg::sacl_state_type st_ff;
  sacl_pkg::sacl_state_type nxt_st;
  logic go_ff;

  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire hit_ctrl = (paddr == `SACL_ADDR_CTRL);
  wire hit_set = (paddr == `SACL_ADDR_SET);
  wire hit_stat = (paddr == `SACL_ADDR_STAT);
  wire mapped = hit_ctrl || hit_set || hit_stat;
  wire busy = (st_ff == sacl_pkg::SACL_SETUP) ||
    (st_ff == sacl_pkg::SACL_PULSE) || (st_ff == sacl_pkg::SACL_HOLD);
  wire [3:0] new_code = step_to_code(step_ff);
  wire [31:0] rd_val = hit_ctrl ? {30'h0, go_ff, direct_ff} :
    hit_set ? {28'h0, step_ff} :
    hit_stat ? {23'h0, busy, load_en_ff, 3'h0, applied_ff} : 32'h0;

  assign pready = 1'b1;
  assign pslverr = acc && !mapped;
  assign prdata = prdata_ff;
  assign {weight_8db_ctl_b, weight_8db_ctl_a, weight_4db_ctl,
    weight_2db_ctl} = code_ff;
  assign latch_load_enable = load_en_ff;

  logic tick_start;
  logic [2:0] tick_cnt;
  logic tick_done;
  sacl_tick #(.W(3)) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .start(tick_start),
    .count(tick_cnt),
    .done(tick_done)
  );

  // ------------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------------
  always_comb
  begin
    nxt_st = st_ff;
    tick_start = 1'b0;
    tick_cnt = 3'(SETUP_CYC - 1);
    case (st_ff)
      sacl_pkg::SACL_IDLE:
        if (direct_ff)
          nxt_st = sacl_pkg::SACL_DIR;
        else if (go_ff)
        begin
          nxt_st = sacl_pkg::SACL_SETUP;
          tick_start = 1'b1;
        end
      sacl_pkg::SACL_SETUP:
        if (tick_done)
        begin
          nxt_st = sacl_pkg::SACL_PULSE;
          tick_start = 1'b1;
          tick_cnt = 3'(PULSE_CYC - 1);
        end
      sacl_pkg::SACL_PULSE:
        if (tick_done)
        begin
          nxt_st = sacl_pkg::SACL_HOLD;
          tick_start = 1'b1;
          tick_cnt = 3'(HOLD_CYC - 1);
        end
      sacl_pkg::SACL_HOLD:
        if (tick_done)
          nxt_st = sacl_pkg::SACL_IDLE;
      // Leave through a hold so the code stands after the enable falls
      sacl_pkg::SACL_DIR:
        if (!direct_ff)
        begin
          nxt_st = sacl_pkg::SACL_HOLD;
          tick_start = 1'b1;
          tick_cnt = 3'(HOLD_CYC - 1);
        end
      default:
        nxt_st = sacl_pkg::SACL_IDLE;
    endcase
  end

  wire nxt_load_en = (st_ff == sacl_pkg::SACL_DIR) ||
    (st_ff == sacl_pkg::SACL_PULSE);
  // Direct mode follows SET only once the enable stands high
  wire load_code = (nxt_st == sacl_pkg::SACL_SETUP) ||
    ((st_ff == sacl_pkg::SACL_DIR) && load_en_ff);
  wire go_set = wr && hit_ctrl && pwdata[`SACL_CTRL_GO];
  wire go_clr = (nxt_st == sacl_pkg::SACL_SETUP);
  // Read data taken in the setup cycle, so it stands at the access edge
  wire rd_setup = psel && !penable && !pwrite;

  // ------------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      direct_ff <= 1'b0;
    else if (wr && hit_ctrl)
      direct_ff <= pwdata[`SACL_CTRL_DIRECT];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      step_ff <= `SACL_STEP_MAX;
    else if (wr && hit_set)
      step_ff <= pwdata[`SACL_SET_W-1:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      go_ff <= 1'b0;
    else if (go_set)
      go_ff <= 1'b1;
    else if (go_clr)
      go_ff <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_ff <= 32'h0;
    else if (rd_setup)
      prdata_ff <= rd_val;
  end

  // ------------------------------------------------------------------
  // Pin sequencing registers
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_ff <= sacl_pkg::SACL_IDLE;
    else
      st_ff <= nxt_st;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      load_en_ff <= 1'b0;
    else
      load_en_ff <= nxt_load_en;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      code_ff <= `SACL_CODE_MAX;
    else if (load_code)
      code_ff <= new_code;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      applied_ff <= `SACL_CODE_MAX;
    else if (load_en_ff)
      applied_ff <= code_ff;
  end
endmodule

/* File: bench/sacl_ctrl_asserts.sv */
// Checker for the attenuator pin sequencing
`timescale 1ns/1ns
module sacl_ctrl_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic weight_2db_ctl,
  input wire logic weight_4db_ctl,
  input wire logic weight_8db_ctl_a,
  input wire logic weight_8db_ctl_b,
  input wire logic latch_load_enable
);
  wire [3:0] code = {weight_8db_ctl_b, weight_8db_ctl_a, weight_4db_ctl,
    weight_2db_ctl};
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_hold;
    $stable(code)[*3];
  endsequence
  property p_b_needs_a;
    weight_8db_ctl_b |-> weight_8db_ctl_a;
  endproperty
  property p_set_before_load;
    $rose(latch_load_enable) |-> $stable(code);
  endproperty
  property p_hold_after_fall;
    $fell(latch_load_enable) |-> s_hold;
  endproperty
  property p_load_pulse;
    $rose(latch_load_enable) |-> latch_load_enable[*3];
  endproperty
  a_b_needs_a: assert property (p_b_needs_a)
    else $error("8 dB b high without a");
  a_set_before_load: assert property (p_set_before_load)
    else $error("code moved as enable rose");
  a_hold_after_fall: assert property (p_hold_after_fall)
    else $error("code moved after enable fell");
  a_load_pulse: assert property (p_load_pulse)
    else $error("load pulse too short");
endmodule

/* File: bench/sacl_atten_model.sv */
// Behavioural attenuator with pull-ups and level latch
`timescale 1ns/1ns
module sacl_atten_model (
  input wire logic weight_2db_ctl,
  input wire logic weight_4db_ctl,
  input wire logic weight_8db_ctl_a,
  input wire logic weight_8db_ctl_b,
  input wire logic latch_load_enable,
  output logic [4:0] atten_db
);
  logic [3:0] pin;
  logic [3:0] held;
  // Floating pins read high
  assign pin = {weight_8db_ctl_b !== 1'h0, weight_8db_ctl_a !== 1'h0,
    weight_4db_ctl !== 1'h0, weight_2db_ctl !== 1'h0};
  initial held = 4'hf;
  always @*
  begin
    if (latch_load_enable !== 1'h0)
      held = pin;
  end
  assign atten_db = 5'h2 * held[0] + 5'h4 * held[1] + 5'h8 * held[2]
    + 5'h8 * held[3];
endmodule

/* File: bench/tb.sv */
// Testbench for the APB attenuator controller
`timescale 1ns/1ns
module tb;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, er, w2, w4, w8a, w8b, load_en;
  logic [4:0] atten;
  int n_fail = 0;
  int comparisons = 0;
  always #4 pclk = ~pclk;
  sacl_ctrl sacl_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .weight_2db_ctl(w2), .weight_4db_ctl(w4), .weight_8db_ctl_a(w8a),
    .weight_8db_ctl_b(w8b), .latch_load_enable(load_en));
  sacl_atten_model sacl_atten_model_inst (.weight_2db_ctl(w2),
    .weight_4db_ctl(w4), .weight_8db_ctl_a(w8a), .weight_8db_ctl_b(w8b),
    .latch_load_enable(load_en), .atten_db(atten));
  // ----
  // Tasks
  // ----
  task automatic xfer(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1)
      @(posedge pclk);
    er = pslverr;
    rd = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic chk(input string n, input logic [31:0] e,
    input logic [31:0] s);
    comparisons++;
    if (s !== e)
    begin
      n_fail++;
      $display("wrong value %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic print_verdict;
    if (n_fail == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    chk("reset atten", 32'h16, 32'(atten));
    xfer(1'h0, 12'h004, 32'h0);
    chk("set reset", 32'hb, rd);
    for (int s = 0; s < 12; s++)
    begin
      xfer(1'h1, 12'h004, 32'(s));
      xfer(1'h1, 12'h000, 32'h2);
      repeat (14) @(posedge pclk);
      chk("latched atten", 32'(2 * s), 32'(atten));
      chk("pin code", 32'(s < 8 ? s : s + 4), 32'({w8b, w8a, w4, w2}));
      xfer(1'h0, 12'h008, 32'h0);
      chk("stat code", 32'(s < 8 ? s : s + 4), rd);
    end
    xfer(1'h1, 12'h004, 32'h0);
    repeat (14) @(posedge pclk);
    chk("held atten", 32'h16, 32'(atten));
    xfer(1'h1, 12'h000, 32'h1);
    for (int s = 3; s < 12; s += 4)
    begin
      xfer(1'h1, 12'h004, 32'(s));
      repeat (4) @(posedge pclk);
      chk("direct atten", 32'(2 * s), 32'(atten));
    end
    xfer(1'h1, 12'h004, 32'hf);
    repeat (4) @(posedge pclk);
    chk("clamped atten", 32'h16, 32'(atten));
    xfer(1'h0, 12'h008, 32'h0);
    chk("stat direct", 32'h8f, rd);
    xfer(1'h1, 12'h000, 32'h0);
    repeat (8) @(posedge pclk);
    xfer(1'h1, 12'h004, 32'h1);
    repeat (14) @(posedge pclk);
    chk("held after direct", 32'h16, 32'(atten));
    xfer(1'h1, 12'h000, 32'h2);
    repeat (14) @(posedge pclk);
    chk("load after direct", 32'h2, 32'(atten));
    xfer(1'h0, 12'h00c, 32'h0);
    chk("unmapped err", 32'h1, 32'(er));
    chk("unmapped data", 32'h0, rd);
    print_verdict;
  end
  initial
  begin
    repeat (1000) @(posedge pclk);
    n_fail++;
    print_verdict;
  end
endmodule
bind sacl_ctrl sacl_ctrl_asserts sacl_ctrl_asserts_inst (.pclk(pclk),
  .presetn(presetn), .weight_2db_ctl(weight_2db_ctl),
  .weight_4db_ctl(weight_4db_ctl), .weight_8db_ctl_a(weight_8db_ctl_a),
  .weight_8db_ctl_b(weight_8db_ctl_b),
  .latch_load_enable(latch_load_enable));
